// ### logic/icts_params.svh
// Timing constants and field widths for the instruction cycle timing sequencer
`ifndef ICTS_PARAMS_SVH
`define ICTS_PARAMS_SVH

// Width of a clock period total and of a bus cycle count
`define ICTS_CLK_W            10
`define ICTS_CYC_W            8
// Width of the register count of a multiple-register move
`define ICTS_REGN_W           5
// Clock periods of one bus cycle with no wait states
`define ICTS_BUS_CYCLE_CLKS   4
// Power-on entry: clocks and reads from reset and halt negated to first instruction
`define ICTS_RESET_ENTRY_CLKS  64
`define ICTS_RESET_ENTRY_READS 12
// Reset value of the elapsed clock register
`define ICTS_ELAPSED_RESET    10'h000

`endif

// ### logic/icts_pkg.sv
// Types shared by the instruction cycle timing sequencer
`include "icts_params.svh"

package icts_pkg;

  // Operation whose timing is being sequenced
  typedef enum logic [5:0] {
    OP_JUMP, OP_SUBROUTINE_JUMP, OP_LOAD_EFFECTIVE_ADDRESS, OP_PUSH_EFFECTIVE_ADDRESS,
    OP_MULTI_REGISTER_MOVE_TO_REG, OP_MULTI_REGISTER_MOVE_TO_MEM,
    OP_EXTENDED_ADD, OP_EXTENDED_SUBTRACT, OP_MEMORY_COMPARE,
    OP_DECIMAL_ADD_EXTENDED, OP_DECIMAL_SUBTRACT_EXTENDED,
    OP_AND_IMMEDIATE_CCB, OP_AND_IMMEDIATE_SW, OP_XOR_IMMEDIATE_CCB, OP_XOR_IMMEDIATE_SW,
    OP_OR_IMMEDIATE_CCB, OP_OR_IMMEDIATE_SW, OP_RESET_OUT, OP_STOP, OP_NOP,
    OP_EXCEPTION_RETURN, OP_RETURN_RESTORE_CONDITIONS, OP_SUBROUTINE_RETURN,
    OP_FRAME_ALLOC, OP_FRAME_RELEASE, OP_STATUS_WORD_READ, OP_STATUS_WORD_LOAD,
    OP_PERIPHERAL_BYTE_MOVE,
    EXC_ADDRESS_ERROR, EXC_BUS_ERROR, EXC_INTERRUPT, EXC_ILLEGAL, EXC_PRIVILEGE,
    EXC_TRACE, EXC_TRAP, EXC_DIVIDE_ZERO, EXC_BOUNDS_CHECK, EXC_OVERFLOW_TRAP
  } icts_op_t;

  // Addressing mode of the operand
  typedef enum logic [3:0] {
    AM_DREG, AM_IND, AM_POSTINC, AM_PREDEC, AM_DISP, AM_INDEX,
    AM_ABS_SHORT, AM_ABS_LONG, AM_PC_DISP, AM_PC_INDEX
  } icts_mode_t;

  typedef enum logic [1:0] {
    SZ_BYTE, SZ_WORD, SZ_LONG
  } icts_size_t;

  // One timing request from the decoder
  typedef struct packed {
    icts_op_t                   op;
    icts_mode_t                 mode;
    icts_size_t                 size;
    logic                       to_mem;
    logic [`ICTS_REGN_W-1:0]    regs;
    logic [`ICTS_CLK_W-1:0]     ea_clocks;
    logic [`ICTS_CYC_W-1:0]     ea_reads;
    logic [`ICTS_CYC_W-1:0]     ea_writes;
  } icts_req_t;

  // Base cost plus per-register increments
  typedef struct packed {
    logic                       ok;
    logic [`ICTS_CLK_W-1:0]     clocks;
    logic [`ICTS_CYC_W-1:0]     reads;
    logic [`ICTS_CYC_W-1:0]     writes;
    logic [4:0]                 per_clocks;
    logic [2:0]                 per_reads;
    logic [2:0]                 per_writes;
  } icts_cost_t;

  // Totals reported at the end of an operation
  typedef struct packed {
    logic [`ICTS_CLK_W-1:0]     clocks;
    logic [`ICTS_CYC_W-1:0]     reads;
    logic [`ICTS_CYC_W-1:0]     writes;
    logic [`ICTS_CLK_W-1:0]     elapsed;
  } icts_report_t;

endpackage

// ### logic/icts_down_counter.sv
// Loadable down counter that stops at zero
`timescale 1ns/1ps
`default_nettype none

module icts_down_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  input  wire logic             dec,
  output logic      [WIDTH-1:0] value,
  output logic                  zero
);

  // Load has priority; decrement never wraps below zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= '0;
    end else if (load) begin
      value <= load_value;
    end else if (dec && value != '0) begin
      value <= value - WIDTH'(1);
    end
  end

  assign zero = (value == '0);

endmodule
`default_nettype wire

// ### logic/icts_bus_cycle.sv
// One processor bus cycle of four clocks, stretched by wait clocks
`timescale 1ns/1ps
`default_nettype none
`include "icts_params.svh"

module icts_bus_cycle (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  input  wire logic start_write,
  input  wire logic bus_wait,
  output logic      busy,
  output logic      finishing,
  output logic      bus_read,
  output logic      bus_write
);

  localparam logic [2:0] LAST_PHASE = 3'(`ICTS_BUS_CYCLE_CLKS - 1);

  logic [2:0] phase;
  logic       is_write;

  // Start clock is phase 0, so back-to-back cycles lose no clock
  assign finishing = busy && phase == LAST_PHASE && !bus_wait;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy     <= 1'b0;
      phase    <= 3'h0;
      is_write <= 1'b0;
    end else if (start) begin
      busy     <= 1'b1;
      phase    <= 3'h1;
      is_write <= start_write;
    end else if (finishing) begin
      busy     <= 1'b0;
      phase    <= 3'h0;
    end else if (busy && phase != LAST_PHASE) begin
      phase    <= phase + 3'h1;
    end
  end

  // Strobes are combinational so they cover the start clock too
  assign bus_read  = (start && !start_write) || (busy && !is_write && !(start && start_write));
  assign bus_write = (start && start_write) || (busy && is_write && !(start && !start_write));

endmodule
`default_nettype wire

// ### logic/icts_timing.sv
// Instruction and exception cycle timing sequencer
`timescale 1ns/1ps
`default_nettype none
`include "icts_params.svh"

module icts_timing (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    halt_n,
  input  wire logic                    req_valid,
  input  wire icts_pkg::icts_req_t     req,
  output logic                         req_ready,
  input  wire logic                    bus_wait,
  output logic                         bus_read,
  output logic                         bus_write,
  output logic                         ext_reset,
  output logic                         executing,
  output logic                         done,
  output logic                         error,
  output icts_pkg::icts_report_t       report
);

  typedef enum logic [1:0] {ST_RESET_HOLD, ST_READY, ST_BUS, ST_IDLE} icts_state_t;

  localparam int CW = `ICTS_CLK_W;
  localparam int YW = `ICTS_CYC_W;

  icts_state_t            state;
  logic [1:0]             rst_sync;
  logic                   rst_n;
  logic [1:0]             halt_sync;
  icts_pkg::icts_cost_t   cost;
  logic [CW-1:0]          tot_clocks;
  logic [YW-1:0]          tot_reads;
  logic [YW-1:0]          tot_writes;
  logic [CW+1:0]          bus_clocks;
  logic [CW-1:0]          idle_clocks;
  logic [CW-1:0]          elapsed;
  icts_pkg::icts_op_t     cur_op;
  logic                   accept;
  logic                   launch;
  logic [CW-1:0]          ld_clocks;
  logic [YW-1:0]          ld_reads;
  logic [YW-1:0]          ld_writes;
  logic [CW-1:0]          ld_idle;
  logic [YW-1:0]          reads_left;
  logic [YW-1:0]          writes_left;
  logic [CW-1:0]          idle_left;
  logic                   reads_zero;
  logic                   writes_zero;
  logic                   idle_zero;
  logic                   cyc_busy;
  logic                   cyc_finishing;
  logic                   cyc_free;
  logic                   start_cycle;
  logic                   start_write;

  // Reset release through two flip-flops; the rest of the block uses the copy
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Halt pin comes from outside, so it is synchronised before use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_sync <= 2'h0;
    end else begin
      halt_sync <= {halt_sync[0], halt_n};
    end
  end

  function automatic icts_pkg::icts_cost_t mk(input int c, input int r, input int w);
    icts_pkg::icts_cost_t k;
    k            = '0;
    k.ok         = 1'b1;
    k.clocks     = CW'(c);
    k.reads      = YW'(r);
    k.writes     = YW'(w);
    return k;
  endfunction

  function automatic icts_pkg::icts_cost_t per(input icts_pkg::icts_cost_t b, input int pc, input int pr,
                                               input int pw);
    icts_pkg::icts_cost_t k;
    k            = b;
    k.per_clocks = 5'(pc);
    k.per_reads  = 3'(pr);
    k.per_writes = 3'(pw);
    return k;
  endfunction

  // Lookup of the zero-wait cost of every operation, mode and size
  // One entry per indexed mode: the index register's size has no field here
  function automatic icts_pkg::icts_cost_t lookup(input icts_pkg::icts_req_t q);
    icts_pkg::icts_cost_t k;
    logic                 lng;
    k   = '0;
    lng = (q.size == icts_pkg::SZ_LONG);
    unique case (q.op)
      icts_pkg::OP_JUMP: begin
        unique case (q.mode)
          icts_pkg::AM_IND:                          k = mk(16, 4, 0);
          icts_pkg::AM_DISP, icts_pkg::AM_ABS_SHORT,
          icts_pkg::AM_PC_DISP:                      k = mk(18, 4, 0);
          icts_pkg::AM_INDEX, icts_pkg::AM_PC_INDEX: k = mk(22, 4, 0);
          icts_pkg::AM_ABS_LONG:                     k = mk(24, 6, 0);
          default:                                   k = '0;
        endcase
      end
      icts_pkg::OP_SUBROUTINE_JUMP: begin
        unique case (q.mode)
          icts_pkg::AM_IND, icts_pkg::AM_PC_INDEX:   k = mk(32, 4, 4);
          icts_pkg::AM_DISP, icts_pkg::AM_ABS_SHORT,
          icts_pkg::AM_PC_DISP:                      k = mk(34, 4, 4);
          icts_pkg::AM_INDEX:                        k = mk(38, 4, 4);
          icts_pkg::AM_ABS_LONG:                     k = mk(40, 6, 4);
          default:                                   k = '0;
        endcase
      end
      icts_pkg::OP_LOAD_EFFECTIVE_ADDRESS: begin
        unique case (q.mode)
          icts_pkg::AM_IND:                          k = mk(8, 2, 0);
          icts_pkg::AM_DISP, icts_pkg::AM_ABS_SHORT,
          icts_pkg::AM_PC_DISP:                      k = mk(16, 4, 0);
          icts_pkg::AM_INDEX, icts_pkg::AM_PC_INDEX: k = mk(20, 4, 0);
          icts_pkg::AM_ABS_LONG:                     k = mk(24, 6, 0);
          default:                                   k = '0;
        endcase
      end
      icts_pkg::OP_PUSH_EFFECTIVE_ADDRESS: begin
        unique case (q.mode)
          icts_pkg::AM_IND:                          k = mk(24, 2, 4);
          icts_pkg::AM_DISP, icts_pkg::AM_ABS_SHORT,
          icts_pkg::AM_PC_DISP:                      k = mk(32, 4, 4);
          icts_pkg::AM_INDEX, icts_pkg::AM_PC_INDEX: k = mk(36, 4, 4);
          icts_pkg::AM_ABS_LONG:                     k = mk(40, 6, 4);
          default:                                   k = '0;
        endcase
      end
      icts_pkg::OP_MULTI_REGISTER_MOVE_TO_REG: begin
        unique case (q.mode)
          icts_pkg::AM_IND, icts_pkg::AM_POSTINC:    k = mk(24, 6, 0);
          icts_pkg::AM_DISP, icts_pkg::AM_PC_DISP:   k = mk(32, 8, 0);
          icts_pkg::AM_INDEX, icts_pkg::AM_PC_INDEX: k = mk(34, 8, 0);
          icts_pkg::AM_ABS_SHORT:                    k = mk(32, lng ? 8 : 10, 0);
          icts_pkg::AM_ABS_LONG:                     k = mk(40, lng ? 8 : 10, 0);
          default:                                   k = '0;
        endcase
        if (lng) begin
          k = per(k, 16, 4, 0);
        end else begin
          k = per(k, 8, (q.mode == icts_pkg::AM_ABS_SHORT) ? 1 : 2, 0);
        end
      end
      icts_pkg::OP_MULTI_REGISTER_MOVE_TO_MEM: begin
        unique case (q.mode)
          icts_pkg::AM_IND, icts_pkg::AM_PREDEC:     k = mk(16, 4, 0);
          icts_pkg::AM_DISP:                         k = mk(24, 6, 0);
          icts_pkg::AM_INDEX:                        k = mk(26, 6, 0);
          icts_pkg::AM_ABS_SHORT:                    k = mk(24, lng ? 8 : 6, 0);
          icts_pkg::AM_ABS_LONG:                     k = mk(32, lng ? 6 : 8, 0);
          default:                                   k = '0;
        endcase
        k = lng ? per(k, 16, 0, 4) : per(k, 8, 0, 2);
      end
      icts_pkg::OP_EXTENDED_ADD, icts_pkg::OP_EXTENDED_SUBTRACT: begin
        if (q.mode == icts_pkg::AM_DREG) begin
          k = mk(lng ? 12 : 8, 2, 0);
        end else if (q.mode == icts_pkg::AM_PREDEC) begin
          unique case (q.size)
            icts_pkg::SZ_BYTE: k = mk(22, 4, 1);
            icts_pkg::SZ_WORD: k = mk(50, 6, 2);
            icts_pkg::SZ_LONG: k = mk(58, 10, 4);
            default:           k = '0;
          endcase
        end
      end
      // memory compare only in memory form
      icts_pkg::OP_MEMORY_COMPARE: begin
        if (q.mode == icts_pkg::AM_POSTINC) begin
          unique case (q.size)
            icts_pkg::SZ_BYTE: k = mk(16, 4, 0);
            icts_pkg::SZ_WORD: k = mk(24, 6, 0);
            icts_pkg::SZ_LONG: k = mk(40, 10, 0);
            default:           k = '0;
          endcase
        end
      end
      icts_pkg::OP_DECIMAL_ADD_EXTENDED, icts_pkg::OP_DECIMAL_SUBTRACT_EXTENDED: begin
        if (q.mode == icts_pkg::AM_DREG) begin
          k = mk(10, 2, 0);
        end else if (q.mode == icts_pkg::AM_PREDEC) begin
          k = mk(20, 4, 1);
        end
      end
      icts_pkg::OP_AND_IMMEDIATE_CCB, icts_pkg::OP_AND_IMMEDIATE_SW,
      icts_pkg::OP_XOR_IMMEDIATE_CCB, icts_pkg::OP_XOR_IMMEDIATE_SW,
      icts_pkg::OP_OR_IMMEDIATE_CCB, icts_pkg::OP_OR_IMMEDIATE_SW: k = mk(32, 6, 0);
      icts_pkg::OP_RESET_OUT:                  k = mk(136, 2, 0);
      icts_pkg::OP_STOP:                       k = mk(4, 0, 0);
      icts_pkg::OP_NOP:                        k = mk(8, 2, 0);
      icts_pkg::OP_EXCEPTION_RETURN,
      icts_pkg::OP_RETURN_RESTORE_CONDITIONS:  k = mk(40, 10, 0);
      icts_pkg::OP_SUBROUTINE_RETURN:          k = mk(32, 8, 0);
      icts_pkg::OP_FRAME_ALLOC:                k = mk(32, 4, 4);
      icts_pkg::OP_FRAME_RELEASE:              k = mk(24, 6, 0);
      icts_pkg::OP_STATUS_WORD_READ:           k = (q.mode == icts_pkg::AM_DREG) ? mk(10, 2, 0) : mk(16, 2, 2);
      icts_pkg::OP_STATUS_WORD_LOAD:           k = mk(18, 4, 0);
      icts_pkg::OP_PERIPHERAL_BYTE_MOVE: begin
        if (q.size != icts_pkg::SZ_BYTE) begin
          if (q.to_mem) begin
            k = lng ? mk(32, 4, 4) : mk(24, 4, 2);
          end else begin
            k = lng ? mk(32, 8, 0) : mk(24, 6, 0);
          end
        end
      end
      // entry counts include stacking, vector and first fetch
      icts_pkg::EXC_ADDRESS_ERROR, icts_pkg::EXC_BUS_ERROR: k = mk(94, 8, 14);
      icts_pkg::EXC_INTERRUPT:                 k = mk(72, 9, 6);
      icts_pkg::EXC_ILLEGAL, icts_pkg::EXC_PRIVILEGE,
      icts_pkg::EXC_TRACE, icts_pkg::EXC_TRAP:  k = mk(62, 8, 6);
      icts_pkg::EXC_DIVIDE_ZERO:               k = mk(66, 8, 6);
      icts_pkg::EXC_BOUNDS_CHECK:              k = mk(68, 8, 6);
      icts_pkg::EXC_OVERFLOW_TRAP:             k = mk(66, 10, 6);
      default:                                 k = '0;
    endcase
    return k;
  endfunction

  // Totals: base plus per-register share plus address calculation share
  always_comb begin
    cost       = lookup(req);
    tot_clocks = cost.clocks + CW'(cost.per_clocks) * CW'(req.regs) + req.ea_clocks;
    tot_reads  = cost.reads + YW'(cost.per_reads) * YW'(req.regs) + req.ea_reads;
    tot_writes = cost.writes + YW'(cost.per_writes) * YW'(req.regs) + req.ea_writes;
  end

  assign req_ready = (state == ST_READY);
  assign accept    = req_valid && req_ready;
  assign launch    = (accept && cost.ok) || (state == ST_RESET_HOLD && halt_sync[1]);

  // power-on entry cost loaded once reset and halt read negated
  always_comb begin
    if (state == ST_RESET_HOLD) begin
      ld_clocks = CW'(`ICTS_RESET_ENTRY_CLKS);
      ld_reads  = YW'(`ICTS_RESET_ENTRY_READS);
      ld_writes = '0;
    end else begin
      ld_clocks = tot_clocks;
      ld_reads  = tot_reads;
      ld_writes = tot_writes;
    end
    // clocks not spent on zero-wait bus cycles are internal idle time
    bus_clocks = (CW + 2)'((ld_reads + ld_writes) * `ICTS_BUS_CYCLE_CLKS);
    ld_idle    = ((CW + 2)'(ld_clocks) > bus_clocks) ? CW'((CW + 2)'(ld_clocks) - bus_clocks) : '0;
  end

  // Reads go out first, then writes, then the idle clocks
  assign cyc_free    = !cyc_busy; // Overlapping the last phase would drop a clock
  assign start_cycle = (state == ST_BUS) && cyc_free && !(reads_zero && writes_zero);
  assign start_write = reads_zero;

  icts_down_counter #(.WIDTH(YW)) u_reads (
    .clk        (clk),
    .rst_n      (rst_n),
    .load       (launch),
    .load_value (ld_reads),
    .dec        (start_cycle && !start_write),
    .value      (reads_left),
    .zero       (reads_zero)
  );

  icts_down_counter #(.WIDTH(YW)) u_writes (
    .clk        (clk),
    .rst_n      (rst_n),
    .load       (launch),
    .load_value (ld_writes),
    .dec        (start_cycle && start_write),
    .value      (writes_left),
    .zero       (writes_zero)
  );

  icts_down_counter #(.WIDTH(CW)) u_idle (
    .clk        (clk),
    .rst_n      (rst_n),
    .load       (launch),
    .load_value (ld_idle),
    .dec        (state == ST_IDLE),
    .value      (idle_left),
    .zero       (idle_zero)
  );

  // a wait clock holds the cycle's last phase, lengthening the total
  icts_bus_cycle u_cycle (
    .clk         (clk),
    .rst_n       (rst_n),
    .start       (start_cycle),
    .start_write (start_write),
    .bus_wait    (bus_wait),
    .busy        (cyc_busy),
    .finishing   (cyc_finishing),
    .bus_read    (bus_read),
    .bus_write   (bus_write)
  );

  // Sequencing of bus phase, idle phase and completion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_RESET_HOLD;
    end else begin
      unique case (state)
        ST_RESET_HOLD, ST_READY: begin
          if (launch) begin
            state <= (ld_reads == '0 && ld_writes == '0) ? ST_IDLE : ST_BUS;
          end
        end
        ST_BUS: begin
          if (cyc_finishing && reads_zero && writes_zero) begin
            state <= idle_zero ? ST_READY : ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (idle_left <= CW'(1)) begin
            state <= ST_READY;
          end
        end
      endcase
    end
  end

  // Completion flags, elapsed clocks and the operation in flight
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      executing <= 1'b0;
      done      <= 1'b0;
      error     <= 1'b0;
      elapsed   <= `ICTS_ELAPSED_RESET;
      cur_op    <= icts_pkg::OP_NOP;
      report    <= '0;
    end else begin
      done  <= 1'b0;
      error <= accept && !cost.ok;
      if (launch) begin
        elapsed <= '0;
        cur_op  <= (state == ST_RESET_HOLD) ? icts_pkg::EXC_ILLEGAL : req.op;
        report  <= '{clocks: ld_clocks, reads: ld_reads, writes: ld_writes, elapsed: '0};
      end else if (state == ST_BUS || state == ST_IDLE) begin
        elapsed <= elapsed + CW'(1);
        if ((state == ST_IDLE && idle_left <= CW'(1)) ||
            (state == ST_BUS && cyc_finishing && reads_zero && writes_zero && idle_zero)) begin
          report.elapsed <= elapsed + CW'(1);
          done           <= executing;
          executing      <= 1'b1;
        end
      end
    end
  end

  // external reset driven through the idle part of the reset-out instruction
  assign ext_reset = (state == ST_IDLE) && executing && (cur_op == icts_pkg::OP_RESET_OUT);

endmodule
`default_nettype wire

// ### sim/icts_timing_checker.sv
// Port checker for the timing sequencer
`timescale 1ns/1ps
`default_nettype none
module icts_timing_checker (
  input wire logic                   clk,
  input wire logic                   resetn,
  input wire logic                   req_valid,
  input wire logic                   req_ready,
  input wire logic                   bus_read,
  input wire logic                   bus_write,
  input wire logic                   ext_reset,
  input wire logic                   executing,
  input wire logic                   done,
  input wire logic                   error,
  input wire icts_pkg::icts_report_t report
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // A bus cycle never lasts under four clocks
  sequence rd4; bus_read [*4]; endsequence
  sequence wr4; bus_write [*4]; endsequence
  rd_cycle_a: assert property ($rose(bus_read) |-> rd4) else $error("short read");
  wr_cycle_a: assert property ($rose(bus_write) |-> wr4) else $error("short write");
  reset_idle_a: assert property (ext_reset |-> !bus_read && !bus_write) else $error("bus in pulse");
  min_time_a: assert property (req_valid && req_ready |=> !done [*4]) else $error("done early");
  done_pulse_a: assert property (done |=> !done) else $error("done long");
  error_ready_a: assert property (error |-> req_ready && !done) else $error("error not ready");
  ready_exec_a: assert property (req_ready |-> executing) else $error("ready early");
  exec_hold_a: assert property (executing |=> executing) else $error("executing fell");
  elapsed_a: assert property (done |-> report.elapsed >= report.clocks) else $error("elapsed short");
endmodule
bind icts_timing icts_timing_checker u_chk (.clk(clk), .resetn(resetn), .req_valid(req_valid),
  .req_ready(req_ready), .bus_read(bus_read), .bus_write(bus_write), .ext_reset(ext_reset),
  .executing(executing), .done(done), .error(error), .report(report));
`default_nettype wire

// ### sim/icts_bus_partner.sv
// Memory side model: answers at once, or slow with one wait clock per bus cycle
`timescale 1ns/1ps
`default_nettype none
module icts_bus_partner (
  input  wire logic clk,
  input  wire logic slow,
  input  wire logic bus_read,
  input  wire logic bus_write,
  output var logic  bus_wait,
  output var int    waits
);
  logic [1:0] ph;
  initial begin
    bus_wait = 1'b0;
    ph = 2'h0;
    waits = 0;
  end
  // wait raised for the fourth phase only
  always @(posedge clk) begin
    if (!(bus_read | bus_write) || (ph == 2'h3 && !bus_wait)) ph <= 2'h0;
    else if (ph != 2'h3) ph <= ph + 2'h1;
    bus_wait <= slow && (bus_read | bus_write) && ph == 2'h2;
    if ((bus_read | bus_write) && bus_wait) waits <= waits + 1;
  end
endmodule
`default_nettype wire

// ### sim/icts_timing_tb_top.sv
// Self-checking bench for the timing sequencer
`timescale 1ns/1ps
`default_nettype none
module icts_timing_tb_top;
  logic                   clk = 1'b0;
  logic                   resetn = 1'b0;
  logic                   req_valid = 1'b0;
  logic                   slow = 1'b0;
  icts_pkg::icts_req_t    req = '0;
  icts_pkg::icts_report_t report;
  logic                   req_ready, bus_wait, bus_read, bus_write, ext_reset, executing, done, error;
  int                     waits, ec, failures = 0, cmp_count = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  icts_timing dut (.clk(clk), .resetn(resetn), .halt_n(resetn), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .bus_wait(bus_wait), .bus_read(bus_read), .bus_write(bus_write),
    .ext_reset(ext_reset), .executing(executing), .done(done), .error(error), .report(report));
  icts_bus_partner mem (.clk(clk), .slow(slow), .bus_read(bus_read), .bus_write(bus_write),
    .bus_wait(bus_wait), .waits(waits));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %0d seen %0d", nm, exp, seen);
    end
  endtask
  // One request; strobe clocks counted up to done, so waits must show in the total
  task automatic run(input icts_pkg::icts_op_t op, input icts_pkg::icts_mode_t md,
                     input icts_pkg::icts_size_t sz, input logic [4:0] n, input int c, input int r, input int w);
    int k, s, sw, w0;
    k = 0;
    s = 0;
    sw = 0;
    ec = 0;
    w0 = waits;
    req = '{op: op, mode: md, size: sz, regs: n, default: '0};
    req_valid = 1'b1;
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    while (done !== 1'b1 && k < 999) begin
      k++;
      s += int'(bus_read | bus_write);
      sw += int'(bus_write);
      ec += int'(ext_reset);
      @(negedge clk);
    end
    chk("clocks", k, c + waits - w0);
    chk("bus clocks", s, 4 * (r + w) + waits - w0);
    chk("write clocks", sw, 4 * w);
    chk("total clocks", report.clocks, c);
    chk("reads", report.reads, r);
    chk("writes", report.writes, w);
    chk("elapsed", report.elapsed, k);
  endtask
  task automatic t_power();
    int k, s;
    k = 0;
    s = 0;
    while (bus_read !== 1'b1 && k < 99) begin
      k++;
      @(negedge clk);
    end
    k = 0;
    while (executing !== 1'b1 && k < 199) begin
      k++;
      s += int'(bus_read);
      @(negedge clk);
    end
    chk("entry clocks", k, 64);
    chk("entry read clocks", s, 48);
    $display("power done");
  endtask
  task automatic t_flow();
    run(icts_pkg::OP_JUMP, icts_pkg::AM_ABS_LONG, icts_pkg::SZ_WORD, 0, 24, 6, 0);
    run(icts_pkg::OP_SUBROUTINE_JUMP, icts_pkg::AM_IND, icts_pkg::SZ_WORD, 0, 32, 4, 4);
    run(icts_pkg::OP_LOAD_EFFECTIVE_ADDRESS, icts_pkg::AM_IND, icts_pkg::SZ_WORD, 0, 8, 2, 0);
    run(icts_pkg::OP_PUSH_EFFECTIVE_ADDRESS, icts_pkg::AM_INDEX, icts_pkg::SZ_WORD, 0, 36, 4, 4);
    run(icts_pkg::OP_MULTI_REGISTER_MOVE_TO_REG, icts_pkg::AM_POSTINC, icts_pkg::SZ_LONG, 3, 72, 18, 0);
    run(icts_pkg::OP_MULTI_REGISTER_MOVE_TO_MEM, icts_pkg::AM_PREDEC, icts_pkg::SZ_WORD, 31, 264, 4, 62);
    $display("flow done");
  endtask
  task automatic t_data();
    run(icts_pkg::OP_EXTENDED_ADD, icts_pkg::AM_PREDEC, icts_pkg::SZ_LONG, 0, 58, 10, 4);
    run(icts_pkg::OP_MEMORY_COMPARE, icts_pkg::AM_POSTINC, icts_pkg::SZ_BYTE, 0, 16, 4, 0);
    run(icts_pkg::OP_DECIMAL_SUBTRACT_EXTENDED, icts_pkg::AM_PREDEC, icts_pkg::SZ_BYTE, 0, 20, 4, 1);
    run(icts_pkg::OP_PERIPHERAL_BYTE_MOVE, icts_pkg::AM_DISP, icts_pkg::SZ_WORD, 0, 24, 6, 0);
    $display("data done");
  endtask
  task automatic t_ctl();
    run(icts_pkg::OP_OR_IMMEDIATE_CCB, icts_pkg::AM_DREG, icts_pkg::SZ_BYTE, 0, 32, 6, 0);
    run(icts_pkg::OP_RESET_OUT, icts_pkg::AM_DREG, icts_pkg::SZ_WORD, 0, 136, 2, 0);
    chk("reset pulse", ec, 128);
    run(icts_pkg::OP_STOP, icts_pkg::AM_DREG, icts_pkg::SZ_WORD, 0, 4, 0, 0);
    run(icts_pkg::OP_RETURN_RESTORE_CONDITIONS, icts_pkg::AM_DREG, icts_pkg::SZ_WORD, 0, 40, 10, 0);
    run(icts_pkg::OP_FRAME_ALLOC, icts_pkg::AM_DREG, icts_pkg::SZ_WORD, 0, 32, 4, 4);
    run(icts_pkg::OP_STATUS_WORD_READ, icts_pkg::AM_IND, icts_pkg::SZ_WORD, 0, 16, 2, 2);
    $display("control done");
  endtask
  task automatic t_exc();
    run(icts_pkg::EXC_ADDRESS_ERROR, icts_pkg::AM_DREG, icts_pkg::SZ_WORD, 0, 94, 8, 14);
    run(icts_pkg::EXC_INTERRUPT, icts_pkg::AM_DREG, icts_pkg::SZ_WORD, 0, 72, 9, 6);
    run(icts_pkg::EXC_BOUNDS_CHECK, icts_pkg::AM_DREG, icts_pkg::SZ_WORD, 0, 68, 8, 6);
    $display("exceptions done");
  endtask
  // Slow memory: every bus cycle gets a wait clock
  task automatic t_wait();
    slow = 1'b1;
    run(icts_pkg::OP_NOP, icts_pkg::AM_DREG, icts_pkg::SZ_WORD, 0, 8, 2, 0);
    chk("stalled", waits > 0, 1);
    slow = 1'b0;
    $display("wait done");
  endtask
  // Jump through a data register is refused with an error pulse
  task automatic t_bad();
    req = '{op: icts_pkg::OP_JUMP, mode: icts_pkg::AM_DREG, size: icts_pkg::SZ_WORD, default: '0};
    req_valid = 1'b1;
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    chk("error ready done", {error, req_ready, done}, 3'b110);
    $display("refusal done");
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence after a 20-cycle reset
  initial begin
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    t_power();
    t_flow();
    t_data();
    t_ctl();
    t_exc();
    t_wait();
    t_bad();
    tally_and_finish();
  end
  // Watchdog far beyond the roughly 1200 cycles the tests need
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
